// ===== fifo_word_mem.sv
// Small word memory with registered read data.
module fifo_word_mem #(
  parameter int ADDR_W = fifo_write_pkg::ADDR_W,
  parameter int DATA_W = fifo_write_pkg::DATA_W
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem_r [2**ADDR_W];

  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule

// ===== fifo_write_pkg.sv
// Package of constants and carrier types for the FIFO write port control.
package fifo_write_pkg;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 6;
  localparam int OFFS_W = 16;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [OFFS_W-1:0] OFFS_RST = 16'h0000;

  typedef enum logic {MODE_SYNC, MODE_ASYNC} write_mode_t;

  typedef struct packed {
    logic write_en_n;
    logic write_select_n;
    logic load_n;
    logic [DATA_W-1:0] data;
  } write_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_t;
endpackage

// ===== fifo_write_port_control.sv
// Write side control of a FIFO: qualification, offset loading, pointer.
// How it works
// - Sync mode stores the data word at each clock edge with enable low, load high and the FIFO not full.
// - Sync mode write enable also qualifies flag offset register loads.
// - Async mode captures one word on each rising edge of the write strobe with enable low, load high and the FIFO not full.
// - Chip select low is a second enable; both must be low to write.
module fifo_write_port_control #(
  parameter int ADDR_W = fifo_write_pkg::ADDR_W,
  parameter int DATA_W = fifo_write_pkg::DATA_W,
  parameter int OFFS_W = fifo_write_pkg::OFFS_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic master_reset_n_in,
  input wire logic async_mode_in,
  input wire logic write_io_level_sel_in,
  input wire logic write_strobe_in,
  input wire fifo_write_pkg::write_req_t req_in,
  input wire logic [ADDR_W:0] rd_ptr_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic [ADDR_W:0] wr_ptr_out,
  output logic full_out,
  output logic write_done_out,
  output logic write_refused_out,
  output logic [OFFS_W-1:0] empty_offset_out,
  output logic [OFFS_W-1:0] full_offset_out,
  output logic io_level_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Configuration follows its inputs at every clock while master reset is low and is then held.
  fifo_write_pkg::write_mode_t mode_r, mode_nxt;
  logic level_r, level_nxt;
  logic strobe_q_r, strobe_q_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    level_nxt = level_r;
    if (!master_reset_n_in)
    begin
      mode_nxt = async_mode_in ? fifo_write_pkg::MODE_ASYNC
                               : fifo_write_pkg::MODE_SYNC;
      level_nxt = write_io_level_sel_in;
    end
    strobe_q_nxt = write_strobe_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_r <= fifo_write_pkg::MODE_SYNC;
      level_r <= 1'b0;
      strobe_q_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      level_r <= level_nxt;
      strobe_q_r <= strobe_q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write qualification. The strobe is taken as synchronous, so its rising
  // edge is seen at the first clock that samples it high; strobes must be at least two clocks apart.
  logic edge_ok;
  logic enabled;
  logic qualified;
  logic accept;

  always_comb
  begin
    enabled = !req_in.write_en_n && !req_in.write_select_n;
    if (mode_r == fifo_write_pkg::MODE_ASYNC)
    begin
      edge_ok = write_strobe_in && !strobe_q_r;
    end
    else
    begin
      edge_ok = 1'b1;
    end
    qualified = master_reset_n_in && edge_ok && enabled;
    accept = qualified && req_in.load_n && !full_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write pointer and flag offset registers.
  logic [ADDR_W:0] wr_ptr_r, wr_ptr_nxt;
  logic [OFFS_W-1:0] ae_off_r, ae_off_nxt;
  logic [OFFS_W-1:0] af_off_r, af_off_nxt;
  logic load_sel_r, load_sel_nxt;
  logic done_r, done_nxt;
  logic refused_r, refused_nxt;

  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    ae_off_nxt = ae_off_r;
    af_off_nxt = af_off_r;
    load_sel_nxt = load_sel_r;
    done_nxt = accept;
    refused_nxt = qualified && req_in.load_n && full_out;
    if (!master_reset_n_in)
    begin
      wr_ptr_nxt = '0;
      ae_off_nxt = fifo_write_pkg::OFFS_RST;
      af_off_nxt = fifo_write_pkg::OFFS_RST;
      load_sel_nxt = 1'b0;
    end
    else if (qualified && !req_in.load_n)
    begin
      // Offsets alternate empty then full, low bits of the data bus.
      if (load_sel_r)
      begin
        af_off_nxt = req_in.data[OFFS_W-1:0];
      end
      else
      begin
        ae_off_nxt = req_in.data[OFFS_W-1:0];
      end
      load_sel_nxt = !load_sel_r;
    end
    else if (accept)
    begin
      wr_ptr_nxt = wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_r <= '0;
      ae_off_r <= fifo_write_pkg::OFFS_RST;
      af_off_r <= fifo_write_pkg::OFFS_RST;
      load_sel_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      ae_off_r <= ae_off_nxt;
      af_off_r <= af_off_nxt;
      load_sel_r <= load_sel_nxt;
      done_r <= done_nxt;
      refused_r <= refused_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and outputs.
  fifo_write_pkg::mem_wr_t mem_wr;

  always_comb
  begin
    mem_wr.addr = wr_ptr_r[ADDR_W-1:0];
    mem_wr.data = req_in.data;
    full_out = (wr_ptr_r[ADDR_W] != rd_ptr_in[ADDR_W]) &&
               (wr_ptr_r[ADDR_W-1:0] == rd_ptr_in[ADDR_W-1:0]);
  end

  fifo_word_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_mem (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(accept),
    .wr_addr_in(mem_wr.addr),
    .wr_data_in(mem_wr.data),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out)
  );

  assign wr_ptr_out = wr_ptr_r;
  assign write_done_out = done_r;
  assign write_refused_out = refused_r;
  assign empty_offset_out = ae_off_r;
  assign full_offset_out = af_off_r;
  assign io_level_out = level_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_sync_write_adv: assert property (
    (master_reset_n_in && mode_r == fifo_write_pkg::MODE_SYNC &&
     !req_in.write_en_n && !req_in.write_select_n && req_in.load_n &&
     !full_out) |=> (wr_ptr_r == $past(wr_ptr_r) + 1'b1) && done_r)
    else $error("sync write did not advance pointer");
  a_offset_load_hold: assert property (
    (master_reset_n_in && !req_in.load_n) |=> $stable(wr_ptr_r))
    else $error("offset load moved write pointer");
  a_offset_load_en: assert property (
    (master_reset_n_in && req_in.write_en_n) |=>
      $stable(ae_off_r) && $stable(af_off_r))
    else $error("offset loaded without enable");
  a_async_no_edge: assert property (
    (master_reset_n_in && mode_r == fifo_write_pkg::MODE_ASYNC &&
     !(write_strobe_in && !strobe_q_r)) |=> !done_r)
    else $error("async write without strobe edge");
  a_async_edge_write: assert property (
    (master_reset_n_in && mode_r == fifo_write_pkg::MODE_ASYNC &&
     write_strobe_in && !strobe_q_r && enabled && req_in.load_n &&
     !full_out) |=> done_r ##1 !done_r)
    else $error("async strobe edge not captured once");
  a_select_gates: assert property (
    (master_reset_n_in && req_in.write_select_n) |=>
      !done_r && $stable(wr_ptr_r))
    else $error("write with chip select high");
  a_mode_static: assert property (
    master_reset_n_in |=> $stable(mode_r) && $stable(level_r))
    else $error("mode changed outside master reset");
  a_full_refuse: assert property (
    (master_reset_n_in && full_out) |=> $stable(wr_ptr_r) && !done_r)
    else $error("write accepted while full");

  c_sync_write: cover property (
    mode_r == fifo_write_pkg::MODE_SYNC ##1 done_r);
  c_async_write: cover property (
    mode_r == fifo_write_pkg::MODE_ASYNC ##1 done_r);
  c_full_refused: cover property (refused_r);
  c_offset_load: cover property (master_reset_n_in && !req_in.load_n &&
    enabled);
endmodule

// ===== fifo_write_port_control_test.sv
// Self-checking bench for the FIFO write port control.
module fifo_write_port_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in, rst_n_in, mrst_n, async_m, lvl, full, done, refused;
  logic io_lvl;
  logic [6:0] rd_ptr, wr_ptr, ptr;
  logic [5:0] rd_addr;
  logic [35:0] rd_data, d, mem [64];
  logic [15:0] e_off, f_off;
  logic [1:0] ec;
  fifo_write_pkg::write_req_t req;
  int error_cnt, checked, cycles;
  logic stb;
  upstream_writer up (.clk_sys_in(clk_sys_in), .async_in(async_m),
    .req_out(req), .write_strobe_out(stb));
  fifo_write_port_control DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .master_reset_n_in(mrst_n), .async_mode_in(async_m),
    .write_io_level_sel_in(lvl), .write_strobe_in(stb), .req_in(req),
    .rd_ptr_in(rd_ptr), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
    .wr_ptr_out(wr_ptr), .full_out(full), .write_done_out(done),
    .write_refused_out(refused), .empty_offset_out(e_off),
    .full_offset_out(f_off), .io_level_out(io_lvl));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic end_sim();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [6:0] nxt(input logic [6:0] p, input logic acc);
    return p + {6'h00, acc};
  endfunction
  // One attempt, then the pulses and pointer just after the edge that takes it.
  task automatic wr(input logic en_n, input logic cs_n, input logic [35:0] dv,
    input logic acc, input logic rf);
    up.put(en_n, cs_n, 1'b1, dv, async_m);
    ptr = nxt(ptr, acc);
    chk(36'(done), 36'(acc));
    chk(36'(refused), 36'(rf));
    chk(36'(wr_ptr), 36'(ptr));
  endtask
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(32'h1075_1c42));
    {rst_n_in, mrst_n, async_m, lvl, rd_ptr, rd_addr, ptr} = '0;
    lvl = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    @(posedge clk_sys_in);
    #1 mrst_n = 1'b1;
    chk(36'(io_lvl), 36'h0_0000_0001);
    for (int i = 0; i < 64; i++)
    begin
      d = 36'({$urandom(), $urandom()});
      ec = 2'($urandom_range(1, 3));
      wr(ec[1], ec[0], ~d, 1'b0, 1'b0);
      mem[i] = d;
      wr(1'b0, 1'b0, d, 1'b1, 1'b0);
    end
    d = 36'({$urandom(), $urandom()});
    up.put(1'b0, 1'b0, 1'b0, d, 1'b0);
    up.put(1'b0, 1'b0, 1'b0, ~d, 1'b0);
    up.put(1'b1, 1'b0, 1'b0, 36'h0_0000_0000, 1'b0);
    @(posedge clk_sys_in);
    #1 chk(36'(e_off), 36'(d[15:0]));
    chk(36'(f_off), {20'h0_0000, ~d[15:0]});
    chk(36'(full), 36'h0_0000_0001);
    wr(1'b0, 1'b0, d, 1'b0, 1'b1);
    up.idle();
    for (int i = 0; i < 64; i++)
    begin
      rd_addr = 6'(i);
      repeat (2) @(posedge clk_sys_in);
      #1 chk(rd_data, mem[i]);
    end
    rd_ptr = 7'h01;
    wr(1'b0, 1'b0, d, 1'b1, 1'b0);
    chk(36'(full), 36'h0_0000_0001);
    up.idle();
    {mrst_n, async_m, lvl, ptr} = {3'h2, 7'h00};
    @(posedge clk_sys_in);
    #1 mrst_n = 1'b1;
    up.idle();
    chk(36'(io_lvl), 36'h0_0000_0000);
    @(posedge clk_sys_in);
    #1;
    for (int i = 0; i < 6; i++)
    begin
      d = 36'({$urandom(), $urandom()});
      wr(1'b0, i == 3, d, i != 3, 1'b0);
      @(posedge clk_sys_in);
      #1 up.put(1'b0, 1'b0, 1'b1, ~d, 1'b0);
      chk(36'(wr_ptr), 36'(ptr));
    end
    end_sim();
  end
endmodule

// ===== upstream_writer.sv
// Upstream writer model that drives the FIFO write port.
module upstream_writer
(
  input wire logic clk_sys_in,
  input wire logic async_in,
  output fifo_write_pkg::write_req_t req_out,
  output logic write_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_out = '{1'b1, 1'b1, 1'b1, 36'h0_0000_0000};
    write_strobe_out = 1'b0;
  end
  // The request stands until the next put or idle, never changing twice
  // in one time step.
  task automatic put(input logic en_n, input logic cs_n, input logic ld_n,
    input logic [35:0] d, input logic stb);
    req_out = '{en_n, cs_n, ld_n, d};
    write_strobe_out = stb;
    @(posedge clk_sys_in);
    #1;
  endtask
  // Idle data is inverted so a stale word never looks like a new one.
  task automatic idle();
    write_strobe_out = 1'b0;
    req_out = '{~async_in, 1'b1, 1'b1, ~req_out.data};
  endtask
endmodule
